// ---- hdl/mrr_device.sv ----
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
module mrr_device #(
  parameter int AVG_BASE_CYCLES = mrr_pkg::AVG_BASE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  mrr_link_if.dev link,
  output logic conv_start,
  output logic [4:0] conv_channel,
  output logic conv_range_attenuator_bit,
  output logic [4:0] conv_lsb_mv,
  input wire logic conv_grant,
  input wire logic conv_done,
  input wire logic [12:0] conv_result,
  input wire logic [9:0] cur_one_sample,
  input wire logic [9:0] cur_hv_sample,
  input wire logic link_started,
  input wire logic [55:0] monitor_groups
);
  // =====================================================
  // link decode
  logic ack_reg, ack_next;
  logic [7:0] rdata_reg, rdata_next;
  logic take, wr, rd;
  assign take = link.req && !ack_reg;
  assign wr = take && link.instr == mrr_pkg::INSTR_WRITE;
  assign rd = take && link.instr == mrr_pkg::INSTR_READ;
  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;

  // =====================================================
  // converter control
  logic [7:0] sel_reg, sel_next;
  logic pend_reg, pend_next, act_reg, act_next, done_reg, done_next;
  logic [12:0] res_reg, res_next;
  logic start_reg, start_next;
  logic [4:0] lsb_reg, lsb_next;

  always_comb
  begin
    sel_next = sel_reg;
    pend_next = pend_reg;
    act_next = act_reg;
    done_next = done_reg;
    res_next = res_reg;
    start_next = 1'b0;
    if (conv_grant && pend_reg)
    begin
      pend_next = 1'b0;
      act_next = 1'b1;
    end
    if (conv_done && act_reg)
    begin
      act_next = 1'b0;
      done_next = 1'b1;
      res_next = conv_result;
    end
    // a fresh request outranks a completion landing in the same cycle
    if (wr && link.addr == mrr_pkg::ADDR_CONV_SEL)
    begin
      sel_next = link.wdata & mrr_pkg::CONV_SEL_MASK;
      start_next = 1'b1;
      pend_next = 1'b1;
      act_next = 1'b0;
      done_next = 1'b0;
    end
    if (sel_next[4:0] == mrr_pkg::CH_HV)
      lsb_next = sel_next[mrr_pkg::RANGE_ATTENUATOR_BIT_BIT] ? mrr_pkg::LSB_HV_HI : mrr_pkg::LSB_HV_LO;
    else
      lsb_next = sel_next[mrr_pkg::RANGE_ATTENUATOR_BIT_BIT] ? mrr_pkg::LSB_STD_HI : mrr_pkg::LSB_STD_LO;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_reg <= mrr_pkg::RESET_BYTE;
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
      done_reg <= 1'b0;
      res_reg <= 13'h0000;
      start_reg <= 1'b0;
      lsb_reg <= mrr_pkg::LSB_STD_LO;
    end
    else
    begin
      sel_reg <= sel_next;
      pend_reg <= pend_next;
      act_reg <= act_next;
      done_reg <= done_next;
      res_reg <= res_next;
      start_reg <= start_next;
      lsb_reg <= lsb_next;
    end
  end

  assign conv_start = start_reg;
  assign conv_channel = sel_reg[4:0];
  assign conv_range_attenuator_bit = sel_reg[mrr_pkg::RANGE_ATTENUATOR_BIT_BIT];
  assign conv_lsb_mv = lsb_reg;

  // =====================================================
  // current averaging
  // accumulators carry three fraction bits so the 7/8 decay does not drift
  logic [7:0] actl_reg, actl_next;
  logic [1:0] asel_reg, asel_next;
  logic [23:0] tick_reg, tick_next;
  logic [12:0] acc_reg [2];
  logic [12:0] acc_next [2];
  logic [23:0] tick_limit;
  logic [9:0] samples [2];
  logic [1:0] avg_en;
  assign tick_limit = 24'(AVG_BASE_CYCLES) << actl_reg[1:0];
  assign samples[0] = cur_one_sample;
  assign samples[1] = cur_hv_sample;
  assign avg_en = {actl_reg[mrr_pkg::HV_AVG_EN_BIT], actl_reg[mrr_pkg::ONE_AVG_EN_BIT]};

  always_comb
  begin
    actl_next = actl_reg;
    asel_next = asel_reg;
    tick_next = tick_reg + 24'h000001;
    if (tick_reg >= tick_limit - 24'h000001)
      tick_next = 24'h000000;
    if (wr && link.addr == mrr_pkg::ADDR_AVG_CTRL)
      actl_next = link.wdata & mrr_pkg::AVG_CTRL_MASK;
    if (wr && link.addr == mrr_pkg::ADDR_AVG_SEL)
      asel_next = link.wdata[1:0];
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_avg
      always_comb
      begin
        acc_next[g] = acc_reg[g];
        if (!avg_en[g])
          acc_next[g] = 13'h0000;
        else if (tick_reg == 24'h000000)
          acc_next[g] = acc_reg[g] - (acc_reg[g] >> 3) + {3'h0, samples[g]};
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          acc_reg[g] <= 13'h0000;
        else
          acc_reg[g] <= acc_next[g];
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      actl_reg <= mrr_pkg::RESET_BYTE;
      asel_reg <= 2'h0;
      tick_reg <= 24'h000000;
    end
    else
    begin
      actl_reg <= actl_next;
      asel_reg <= asel_next;
      tick_reg <= tick_next;
    end
  end

  logic [9:0] avg_out;
  always_comb
  begin
    case (asel_reg)
      mrr_pkg::AVG_SEL_ONE: avg_out = acc_reg[0][12:3];
      mrr_pkg::AVG_SEL_HV: avg_out = acc_reg[1][12:3];
      default: avg_out = 10'h000;
    endcase
  end

  // =====================================================
  // status group record
  logic [3:0] msel_reg, msel_next;
  logic [7:0] rec_reg, rec_next;
  logic valid_reg, valid_next;

  always_comb
  begin
    msel_next = msel_reg;
    valid_next = link_started;
    if (wr && link.addr == mrr_pkg::ADDR_MON_SEL)
    begin
      msel_next = link.wdata[3:0];
      valid_next = 1'b0;
    end
    case (msel_reg)
      4'h0: rec_next = {1'b0, monitor_groups[6:5], 5'h05};
      4'h6: rec_next = {monitor_groups[55:51], 3'h5};
      4'h1: rec_next = monitor_groups[15:8] & 8'hf7;
      4'h2, 4'h3, 4'h4, 4'h5: rec_next = monitor_groups[msel_reg * 8 +: 8];
      default: rec_next = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      msel_reg <= 4'h0;
      rec_reg <= 8'h00;
      valid_reg <= 1'b0;
    end
    else
    begin
      msel_reg <= msel_next;
      rec_reg <= rec_next;
      valid_reg <= valid_next;
    end
  end

  // =====================================================
  // read mux
  always_comb
  begin
    ack_next = take;
    rdata_next = rdata_reg;
    if (rd)
    begin
      case (link.addr)
        mrr_pkg::ADDR_CONV_SEL: rdata_next = sel_reg;
        mrr_pkg::ADDR_CONV_LOW: rdata_next = {res_reg[4:0], pend_reg, act_reg, done_reg};
        mrr_pkg::ADDR_CONV_HIGH: rdata_next = res_reg[12:5];
        mrr_pkg::ADDR_AVG_CTRL: rdata_next = actl_reg;
        mrr_pkg::ADDR_AVG_SEL: rdata_next = {6'h00, asel_reg};
        mrr_pkg::ADDR_AVG_LOW: rdata_next = avg_out[7:0];
        mrr_pkg::ADDR_AVG_HIGH: rdata_next = {6'h00, avg_out[9:8]};
        mrr_pkg::ADDR_MON_SEL: rdata_next = {valid_reg, 3'h0, msel_reg};
        mrr_pkg::ADDR_MON_REC: rdata_next = rec_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : mrr_device

// ---- hdl/mrr_pkg.sv ----
package mrr_pkg;
  // =====================================================
  // link instruction codes
  localparam logic [7:0] INSTR_WRITE = 8'h51;
  localparam logic [7:0] INSTR_READ = 8'h52;
  // =====================================================
  // measurement register addresses
  localparam logic [7:0] ADDR_CONV_SEL = 8'h00;
  localparam logic [7:0] ADDR_CONV_LOW = 8'h01;
  localparam logic [7:0] ADDR_CONV_HIGH = 8'h02;
  localparam logic [7:0] ADDR_AVG_CTRL = 8'h03;
  localparam logic [7:0] ADDR_AVG_SEL = 8'h04;
  localparam logic [7:0] ADDR_AVG_LOW = 8'h05;
  localparam logic [7:0] ADDR_AVG_HIGH = 8'h06;
  localparam logic [7:0] ADDR_MON_SEL = 8'h07;
  localparam logic [7:0] ADDR_MON_REC = 8'h08;
  // =====================================================
  // field positions and write masks
  localparam int RANGE_ATTENUATOR_BIT_BIT = 7;
  localparam logic [7:0] CONV_SEL_MASK = 8'h9f;
  localparam int PENDING_BIT = 2;
  localparam int ACTIVE_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int HV_AVG_EN_BIT = 5;
  localparam int ONE_AVG_EN_BIT = 2;
  localparam logic [7:0] AVG_CTRL_MASK = 8'h27;
  localparam logic [1:0] AVG_SEL_ONE = 2'h0;
  localparam logic [1:0] AVG_SEL_HV = 2'h3;
  localparam int MON_VALID_BIT = 7;
  localparam logic [3:0] MON_SEL_LAST = 4'h6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // =====================================================
  // converter channel codes
  localparam logic [4:0] CH_STD_LAST = 5'h08;
  localparam logic [4:0] CH_HV = 5'h09;
  localparam logic [4:0] CH_SUPPLY = 5'h0c;
  localparam logic [4:0] CH_CUR_ONE = 5'h10;
  localparam logic [4:0] CH_CUR_HV = 5'h13;
  // millivolts per count
  localparam logic [4:0] LSB_STD_LO = 5'h02;
  localparam logic [4:0] LSB_STD_HI = 5'h06;
  localparam logic [4:0] LSB_HV_LO = 5'h08;
  localparam logic [4:0] LSB_HV_HI = 5'h10;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int AVG_BASE_MS = 1;
  localparam int AVG_BASE_CYCLES = AVG_BASE_MS * 1000000000 / CLK_PERIOD_PS;
  // =====================================================
  // controller register map (axi4-lite byte addresses)
  localparam logic [3:0] HOST_CMD = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam logic [3:0] HOST_DATA = 4'h8;
  localparam int CMD_READ_BIT = 16;
  localparam int CMD_CONV_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : mrr_pkg

// ---- hdl/mrr_link_if.sv ----
`timescale 1ns/10ps
interface mrr_link_if;
  logic req;
  logic [7:0] instr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev (input req, input instr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output instr, output addr, output wdata, input ack, input rdata);
endinterface : mrr_link_if

// ---- hdl/mrr_host.sv ----
`timescale 1ns/10ps
module mrr_host (
  input wire logic aclk,
  input wire logic aresetn,
  mrr_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_POLL, ST_HIGH} mrr_st_t;
  mrr_st_t st_reg, st_next;
  logic req_reg, req_next, rd_reg, rd_next;
  logic [7:0] addr_reg, addr_next, wd_reg, wd_next, last_reg, last_next;
  logic [12:0] res_reg, res_next;
  logic refused_reg, refused_next;
  logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next, arr_reg, arr_next, rv_reg, rv_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [3:0] awa_reg, awa_next;
  logic [31:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic cmd_go, busy, legal;
  logic [4:0] ch;

  assign busy = st_reg != ST_IDLE;
  assign ch = wdat_next[4:0];
  // =====================================================
  // only documented channel codes go out on conversion commands; plain link writes pass any byte
  assign legal = ch <= mrr_pkg::CH_STD_LAST || ch == mrr_pkg::CH_HV || ch == mrr_pkg::CH_SUPPLY
    || ch == mrr_pkg::CH_CUR_ONE || ch == mrr_pkg::CH_CUR_HV;

  always_comb
  begin
    awr_next = awr_reg;
    wr_next = wr_reg;
    aw_held_next = aw_held_reg || (s_axi_awvalid && awr_reg);
    w_held_next = w_held_reg || (s_axi_wvalid && wr_reg);
    awa_next = (s_axi_awvalid && awr_reg) ? s_axi_awaddr : awa_reg;
    wdat_next = (s_axi_wvalid && wr_reg) ? s_axi_wdata : wdat_reg;
    bv_next = bv_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    cmd_go = 1'b0;
    if (aw_held_next && w_held_next && !bv_next)
    begin
      bv_next = 1'b1;
      bresp_next = (awa_next == mrr_pkg::HOST_CMD) ? mrr_pkg::RESP_OKAY : mrr_pkg::RESP_DECERR;
      cmd_go = awa_next == mrr_pkg::HOST_CMD && s_axi_wstrb != 4'h0;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
    end
    awr_next = !aw_held_next && !bv_next;
    wr_next = !w_held_next && !bv_next;
    rv_next = rv_reg && !s_axi_rready;
    rdat_next = rdat_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arr_reg)
    begin
      rv_next = 1'b1;
      rresp_next = mrr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        mrr_pkg::HOST_STATUS: rdat_next = {30'h0, refused_reg, busy};
        mrr_pkg::HOST_DATA: rdat_next = {3'h0, res_reg, 8'h00, last_reg};
        mrr_pkg::HOST_CMD: rdat_next = {16'h0000, addr_reg, wd_reg};
        default:
        begin
          rdat_next = 32'h00000000;
          rresp_next = mrr_pkg::RESP_DECERR;
        end
      endcase
    end
    arr_next = !rv_next;
  end

  // =====================================================
  // link sequencer
  always_comb
  begin
    st_next = st_reg;
    req_next = req_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    last_next = last_reg;
    res_next = res_reg;
    refused_next = refused_reg;
    if (cmd_go)
    begin
      // a command while busy would break the done handshake
      if (busy || (wdat_next[mrr_pkg::CMD_CONV_BIT] && !legal))
        refused_next = 1'b1;
      else
      begin
        refused_next = 1'b0;
        req_next = 1'b1;
        if (wdat_next[mrr_pkg::CMD_CONV_BIT])
        begin
          rd_next = 1'b0;
          addr_next = mrr_pkg::ADDR_CONV_SEL;
          wd_next = wdat_next[7:0] & mrr_pkg::CONV_SEL_MASK;
          st_next = ST_POLL;
        end
        else
        begin
          rd_next = wdat_next[mrr_pkg::CMD_READ_BIT];
          addr_next = wdat_next[15:8];
          wd_next = wdat_next[7:0];
          st_next = ST_XFER;
        end
      end
    end
    // a refused command must not swallow a link answer in the same cycle
    if (req_reg && link.ack)
    begin
      req_next = 1'b0;
      if (rd_reg)
        last_next = link.rdata;
      case (st_reg)
        ST_POLL:
        begin
          req_next = 1'b1;
          rd_next = 1'b1;
          if (rd_reg && link.rdata[mrr_pkg::DONE_BIT])
          begin
            res_next[4:0] = link.rdata[7:3];
            addr_next = mrr_pkg::ADDR_CONV_HIGH;
            st_next = ST_HIGH;
          end
          else
            addr_next = mrr_pkg::ADDR_CONV_LOW;
        end
        ST_HIGH:
        begin
          res_next[12:5] = link.rdata;
          st_next = ST_IDLE;
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= ST_IDLE;
      req_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 8'h00;
      wd_reg <= 8'h00;
      last_reg <= 8'h00;
      res_reg <= 13'h0000;
      refused_reg <= 1'b0;
      awr_reg <= 1'b0;
      wr_reg <= 1'b0;
      bv_reg <= 1'b0;
      arr_reg <= 1'b0;
      rv_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awa_reg <= 4'h0;
      wdat_reg <= 32'h00000000;
      rdat_reg <= 32'h00000000;
      bresp_reg <= mrr_pkg::RESP_OKAY;
      rresp_reg <= mrr_pkg::RESP_OKAY;
    end
    else
    begin
      st_reg <= st_next;
      req_reg <= req_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      last_reg <= last_next;
      res_reg <= res_next;
      refused_reg <= refused_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      bv_reg <= bv_next;
      arr_reg <= arr_next;
      rv_reg <= rv_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awa_reg <= awa_next;
      wdat_reg <= wdat_next;
      rdat_reg <= rdat_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
    end
  end

  assign link.req = req_reg;
  assign link.instr = rd_reg ? mrr_pkg::INSTR_READ : mrr_pkg::INSTR_WRITE;
  assign link.addr = addr_reg;
  assign link.wdata = wd_reg;
  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rdat_reg;
  assign s_axi_rresp = rresp_reg;
endmodule : mrr_host

// ---- testbench/mrr_link_sva.sv ----
`timescale 1ns/10ps
module mrr_link_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic [7:0] instr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  // ==========================================
  // shadow of the last converter select byte
  logic [7:0] sel_reg;
  logic [7:0] sel_next;

  always_comb
  begin
    sel_next = sel_reg;
    if (req && !ack && instr == mrr_pkg::INSTR_WRITE && addr == 8'h00)
    begin
      sel_next = wdata & mrr_pkg::CONV_SEL_MASK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_reg <= 8'h00;
    end
    else
    begin
      sel_reg <= sel_next;
    end
  end

  // ==========================================
  // link transfer checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_take;
    req && !ack;
  endsequence

  // address is still held by the host while ack is up
  sequence s_read(logic [7:0] a);
    ack && req && instr == mrr_pkg::INSTR_READ && addr == a;
  endsequence

  a_ack_follows: assert property (s_take |=> ack)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_holds: assert property (s_take |=> req && $stable(addr) && $stable(instr))
    else $error("request dropped before ack");
  a_rdata_holds: assert property (!ack |-> $stable(rdata))
    else $error("read byte changed without ack");
  a_status_onehot: assert property (s_read(8'h01) |-> $onehot0(rdata[2:0]))
    else $error("more than one status bit set");
  a_sel_readback: assert property (s_read(8'h00) |-> rdata == sel_reg)
    else $error("select byte read back wrong");
  a_avg_high_zero: assert property (s_read(8'h06) |-> rdata[7:2] == 6'h00)
    else $error("average high byte upper bits set");
  a_ctrl_zeros: assert property (s_read(8'h03) |-> (rdata & ~mrr_pkg::AVG_CTRL_MASK) == 8'h00)
    else $error("averaging control fixed bits set");
  a_mon_sel_zeros: assert property (s_read(8'h07) |-> rdata[6:4] == 3'h0)
    else $error("group select fixed bits set");
  a_unmapped_zero: assert property (ack && req && instr == mrr_pkg::INSTR_READ && addr > 8'h08
    |-> rdata == 8'h00) else $error("unmapped read not zero");
endmodule : mrr_link_sva

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_range_attenuator_bit;
  logic [1:0] bresp, rresp;
  logic conv_grant = 1'b0, conv_done = 1'b0, link_started = 1'b0;
  logic [12:0] conv_result = 13'h0, res;
  logic [9:0] cur_one = 10'h0, cur_hv = 10'h0, s_one, s_hv;
  logic [55:0] groups = 56'h0;
  logic [4:0] conv_channel, conv_lsb;
  logic [7:0] x;
  logic [33:0] got;
  logic [10:0] cv;
  int error_cnt = 0, compares = 0;
  typedef struct packed { logic [33:0] v; logic [33:0] m; } mrr_exp_t;
  mrr_exp_t aq[$];
  mrr_exp_t e;
  logic [10:0] cq[$];
  localparam logic [4:0] CHS [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0c, 5'h10, 5'h13};

  mrr_link_if link();
  mrr_device #(.AVG_BASE_CYCLES(4)) u_mrr_device (.aclk(aclk), .aresetn(aresetn), .link(link),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_range_attenuator_bit(conv_range_attenuator_bit),
    .conv_lsb_mv(conv_lsb), .conv_grant(conv_grant), .conv_done(conv_done),
    .conv_result(conv_result), .cur_one_sample(cur_one), .cur_hv_sample(cur_hv),
    .link_started(link_started), .monitor_groups(groups));
  mrr_host u_mrr_host (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  mrr_link_sva u_mrr_link_sva (.aclk(aclk), .aresetn(aresetn), .req(link.req),
    .instr(link.instr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  assign got = rvalid ? {rresp, rdata} : {bresp, 32'h0};

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  task summarize;
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task fail_out;
    error_cnt++;
    summarize();
  endtask : fail_out

  // ==========================================
  // axi4-lite master, one transfer at a time
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    aq.push_back({{r, 32'h0}, {2'h3, 32'h0}});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 200) fail_out();
  endtask : axi_wr

  // a zero mask marks a poll whose answer is not judged
  task axi_rd(input logic [3:0] a, input logic [1:0] r, input logic [31:0] v, input logic [31:0] m);
    int n;
    aq.push_back({{r, v}, {{2{|m}}, m}});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rready <= 1'b0;
    if (n == 200) fail_out();
  endtask : axi_rd

  task wait_idle;
    int n;
    for (n = 0; n < 100; n++)
    begin
      axi_rd(mrr_pkg::HOST_STATUS, 2'h0, 32'h0, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 100) fail_out();
  endtask : wait_idle

  task lnk_wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(mrr_pkg::HOST_CMD, {16'h0, a, d}, 2'h0);
    wait_idle();
  endtask : lnk_wr

  task lnk_rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    axi_wr(mrr_pkg::HOST_CMD, {15'h0, 1'b1, a, 8'h00}, 2'h0);
    wait_idle();
    axi_rd(mrr_pkg::HOST_DATA, 2'h0, {24'h0, v}, {24'h0, m});
  endtask : lnk_rd

  task pulse(input logic g, input logic [12:0] r);
    @(posedge aclk);
    conv_grant <= g;
    conv_done <= !g;
    conv_result <= r;
    @(posedge aclk);
    conv_grant <= 1'b0;
    conv_done <= 1'b0;
  endtask : pulse

  task conv(input logic [7:0] s, input logic [12:0] r);
    int n;
    axi_wr(mrr_pkg::HOST_CMD, {14'h0, 2'b10, 8'h00, s}, 2'h0);
    for (n = 0; n < 100 && conv_start !== 1'b1; n++) @(posedge aclk);
    if (n == 100) fail_out();
    pulse(1'b1, 13'h0);
    axi_wr(mrr_pkg::HOST_CMD, {14'h0, 2'b10, 8'h00, s}, 2'h0);
    axi_rd(mrr_pkg::HOST_STATUS, 2'h0, 32'h3, 32'h3);
    pulse(1'b0, r);
    wait_idle();
    axi_rd(mrr_pkg::HOST_DATA, 2'h0, {3'h0, r, 16'h0}, 32'h1fff0000);
    lnk_rd(8'h01, {r[4:0], 3'b001}, 8'hff);
    lnk_rd(8'h02, r[12:5], 8'hff);
  endtask : conv

  // ==========================================
  // response scoreboard
  always @(posedge aclk)
  begin
    if ((rvalid && rready) || (bvalid && bready))
    begin
      if (aq.size() == 0)
        error_cnt++;
      else
      begin
        e = aq.pop_front();
        if (e.m != 34'h0) `CHK(got & e.m, e.v & e.m)
      end
    end
    if (conv_start === 1'b1)
    begin
      cv = (cq.size() > 0) ? cq.pop_front() : 11'h7ff;
      `CHK({conv_range_attenuator_bit, conv_channel, conv_lsb}, cv)
    end
  end

  // ==========================================
  // main sequence
  initial
  begin
    int i, a, k;
    void'($urandom(20087));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (k = 0; k < 9; k++) lnk_rd(k[7:0], (k == 8) ? 8'h05 : 8'h00, 8'hff);
    res = 13'($urandom);
    cq.push_back({1'b0, 5'h03, 5'h02});
    lnk_wr(8'h00, 8'h03);
    lnk_rd(8'h01, 8'h04, 8'h07);
    pulse(1'b1, 13'h0);
    lnk_rd(8'h01, 8'h02, 8'h07);
    pulse(1'b0, res);
    lnk_rd(8'h01, {res[4:0], 3'b001}, 8'hff);
    lnk_wr(8'h02, 8'hff);
    lnk_rd(8'h02, res[12:5], 8'hff);
    for (a = 0; a < 2; a++)
      for (i = 0; i < 13; i++)
      begin
        cq.push_back({a[0], CHS[i], (CHS[i] == 5'h09) ? (a[0] ? 5'h10 : 5'h08)
          : (a[0] ? 5'h06 : 5'h02)});
        res = 13'($urandom);
        conv({a[0], 2'b11, CHS[i]}, res);
        lnk_rd(8'h00, {a[0], 2'b00, CHS[i]}, 8'hff);
      end
    axi_wr(mrr_pkg::HOST_CMD, {14'h0, 2'b10, 8'h00, 8'h0a}, 2'h0);
    axi_rd(mrr_pkg::HOST_STATUS, 2'h0, 32'h2, 32'h2);
    axi_rd(4'hc, 2'h3, 32'h0, 32'hffffffff);
    axi_wr(4'h4, 32'h0, 2'h3);
    lnk_rd(8'h20, 8'h00, 8'hff);
    s_hv = 10'($urandom);
    s_one = 10'($urandom);
    cur_hv <= s_hv;
    cur_one <= s_one;
    lnk_wr(8'h03, 8'h20);
    repeat (1200) @(posedge aclk);
    lnk_wr(8'h04, 8'h03);
    lnk_rd(8'h05, s_hv[7:0], 8'hff);
    lnk_rd(8'h06, {6'h0, s_hv[9:8]}, 8'hff);
    s_hv = 10'($urandom);
    cur_hv <= s_hv;
    for (k = 0; k < 4; k++)
    begin
      lnk_wr(8'h03, 8'hfc | k[7:0]);
      lnk_rd(8'h03, 8'h24 | k[7:0], 8'hff);
    end
    repeat (10000) @(posedge aclk);
    lnk_rd(8'h05, s_hv[7:0], 8'hff);
    lnk_wr(8'h04, 8'hfc);
    lnk_rd(8'h04, 8'h00, 8'hff);
    lnk_rd(8'h05, s_one[7:0], 8'hff);
    lnk_rd(8'h06, {6'h0, s_one[9:8]}, 8'hff);
    groups <= 56'({$urandom, $urandom});
    link_started <= 1'b1;
    for (k = 0; k < 9; k++)
    begin
      lnk_wr(8'h07, k[7:0]);
      case (k)
        0: x = {1'b0, groups[6:5], 5'b00101};
        1: x = groups[15:8] & 8'hf7;
        6: x = {groups[55:51], 3'b101};
        7, 8: x = 8'h00;
        default: x = groups[k * 8 +: 8];
      endcase
      lnk_rd(8'h08, x, 8'hff);
      lnk_rd(8'h07, {1'b1, 3'h0, k[3:0]}, 8'hff);
    end
    lnk_wr(8'h07, 8'h02);
    groups <= ~groups;
    lnk_rd(8'h08, ~groups[23:16], 8'hff);
    link_started <= 1'b0;
    lnk_wr(8'h07, 8'h02);
    lnk_rd(8'h07, 8'h02, 8'hff);
    summarize();
  end
endmodule : tb_top
